// ==== logic/usb_ep_consts.svh ====
// constants for the endpoint token responder
`ifndef USB_EP_CONSTS_SVH
`define USB_EP_CONSTS_SVH
`define UEP_MODE_ADDR 8'h00
`define UEP_COUNT_ADDR 8'h04
`define UEP_STATUS_ADDR 8'h08
`define UEP_MODE_LSB 0
`define UEP_CTRL_BIT 4
`define UEP_STALL_BIT 7
`define UEP_COUNT_LSB 0
`define UEP_ST_SETUP_BIT 0
`define UEP_ST_IN_BIT 1
`define UEP_ST_OUT_BIT 2
`define UEP_ST_ACK_BIT 3
`define UEP_ST_RESP_LSB 4
`define UEP_MODE_RST 4'h0
`define UEP_COUNT_RST 4'h0
`define UEP_SETUP_MAX_LEN 5'h0A
`endif

// ==== logic/usb_ep_pkg.sv ====
// types shared by the endpoint token responder
`default_nettype none
package usb_ep_pkg;
  typedef enum logic [1:0] {
    TOK_SETUP = 2'h0,
    TOK_IN = 2'h1,
    TOK_OUT = 2'h2
  } token_kind_t;
  typedef enum logic [2:0] {
    RESP_NONE = 3'h0,
    RESP_ACK = 3'h1,
    RESP_NAK = 3'h2,
    RESP_STALL = 3'h3,
    RESP_TX_ZERO = 3'h4,
    RESP_TX_COUNT = 3'h5,
    RESP_TAKE = 3'h6
  } resp_kind_t;
  typedef enum logic [3:0] {
    MODE_DISABLE = 4'h0,
    MODE_NAK_INOUT = 4'h1,
    MODE_STATUS_OUT = 4'h2,
    MODE_STALL_INOUT = 4'h3,
    MODE_IGNORE_INOUT = 4'h4,
    MODE_ISO_OUT = 4'h5,
    MODE_STATUS_IN = 4'h6,
    MODE_ISO_IN = 4'h7,
    MODE_NAK_OUT = 4'h8,
    MODE_ACK_OUT = 4'h9,
    MODE_NAK_OUT_STIN = 4'hA,
    MODE_ACK_OUT_STIN = 4'hB,
    MODE_NAK_IN = 4'hC,
    MODE_ACK_IN = 4'hD,
    MODE_NAK_IN_STOUT = 4'hE,
    MODE_ACK_IN_STOUT = 4'hF
  } ep_mode_t;
  typedef enum logic {
    ST_IDLE = 1'h0,
    ST_WAIT_HOST_ACK = 1'h1
  } in_state_t;
  typedef struct packed {
    logic valid;
    token_kind_t kind;
    logic crc_ok;
    logic data_toggle_flag;
    logic [4:0] length;
  } token_t;
  typedef struct packed {
    logic valid;
    resp_kind_t kind;
    logic [3:0] byte_count;
  } resp_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
endpackage : usb_ep_pkg
`default_nettype wire

// ==== logic/ep_mode_decoder.sv ====
// combinational answer table for one token under one mode
`timescale 1ns/100ps
`default_nettype none
module ep_mode_decoder
(
  // mode and token
  input wire usb_ep_pkg::ep_mode_t mode,
  input wire logic stall,
  input wire usb_ep_pkg::token_kind_t kind,
  // packet checks
  input wire logic setup_ok,
  input wire logic status_ok,
  // answer
  output usb_ep_pkg::resp_kind_t resp
);
  typedef enum logic [2:0] {
    A_IGNORE, A_ACCEPT, A_NAK, A_STALL, A_CHECK, A_TX0, A_TXC, A_ALWAYS
  } act_t;

  act_t setup_act;
  act_t in_act;
  act_t out_act;
  act_t act;

  always_comb
  begin
    setup_act = A_IGNORE;
    in_act = A_IGNORE;
    out_act = A_IGNORE;
    case (mode)
      usb_ep_pkg::MODE_DISABLE:
      begin
        setup_act = A_IGNORE;
      end
      usb_ep_pkg::MODE_NAK_INOUT:
      begin
        setup_act = A_ACCEPT;
        in_act = A_NAK;
        out_act = A_NAK;
      end
      usb_ep_pkg::MODE_STATUS_OUT:
      begin
        setup_act = A_ACCEPT;
        in_act = A_STALL;
        out_act = A_CHECK;
      end
      usb_ep_pkg::MODE_STALL_INOUT:
      begin
        setup_act = A_ACCEPT;
        in_act = A_STALL;
        out_act = A_STALL;
      end
      usb_ep_pkg::MODE_IGNORE_INOUT:
      begin
        setup_act = A_ACCEPT;
      end
      usb_ep_pkg::MODE_ISO_OUT:
      begin
        out_act = A_ALWAYS;
      end
      usb_ep_pkg::MODE_STATUS_IN:
      begin
        setup_act = A_ACCEPT;
        in_act = A_TX0;
        out_act = A_STALL;
      end
      usb_ep_pkg::MODE_ISO_IN:
      begin
        in_act = A_TXC;
      end
      usb_ep_pkg::MODE_NAK_OUT:
      begin
        out_act = A_NAK;
      end
      usb_ep_pkg::MODE_ACK_OUT:
      begin
        out_act = stall ? A_STALL : A_ACCEPT;
      end
      usb_ep_pkg::MODE_NAK_OUT_STIN:
      begin
        setup_act = A_ACCEPT;
        in_act = A_TX0;
        out_act = A_NAK;
      end
      usb_ep_pkg::MODE_ACK_OUT_STIN:
      begin
        setup_act = A_ACCEPT;
        in_act = A_TX0;
        out_act = A_ACCEPT;
      end
      usb_ep_pkg::MODE_NAK_IN:
      begin
        in_act = A_NAK;
      end
      usb_ep_pkg::MODE_ACK_IN:
      begin
        in_act = stall ? A_STALL : A_TXC;
      end
      usb_ep_pkg::MODE_NAK_IN_STOUT:
      begin
        setup_act = A_ACCEPT;
        in_act = A_NAK;
        out_act = A_CHECK;
      end
      usb_ep_pkg::MODE_ACK_IN_STOUT:
      begin
        setup_act = A_ACCEPT;
        in_act = A_TXC;
        out_act = A_CHECK;
      end
      default:
      begin
        setup_act = A_IGNORE;
      end
    endcase
  end

  always_comb
  begin
    case (kind)
      usb_ep_pkg::TOK_SETUP: act = setup_act;
      usb_ep_pkg::TOK_IN: act = in_act;
      usb_ep_pkg::TOK_OUT: act = out_act;
      default: act = A_IGNORE;
    endcase
    case (act)
      // a damaged or oversized setup gets no handshake
      A_ACCEPT: resp = (kind != usb_ep_pkg::TOK_SETUP || setup_ok) ? usb_ep_pkg::RESP_ACK
                       : usb_ep_pkg::RESP_NONE;
      A_NAK: resp = usb_ep_pkg::RESP_NAK;
      A_STALL: resp = usb_ep_pkg::RESP_STALL;
      A_CHECK: resp = status_ok ? usb_ep_pkg::RESP_ACK : usb_ep_pkg::RESP_STALL;
      A_TX0: resp = usb_ep_pkg::RESP_TX_ZERO;
      A_TXC: resp = usb_ep_pkg::RESP_TX_COUNT;
      A_ALWAYS: resp = usb_ep_pkg::RESP_TAKE;
      default: resp = usb_ep_pkg::RESP_NONE;
    endcase
  end
endmodule : ep_mode_decoder
`default_nettype wire

// ==== logic/usb_endpoint_mode_responder.sv ====
// endpoint token responder with apb mode/count/status registers
//
// Functional notes
// - mode comes from mode register bits 3..0
// - 0000 ignores setup, in and out
// - 0001 acks setup, naks in and out
// - control setup forces mode 0001 unless 0000
// - control modes 0010/0011/0100/0110 accept setup
// - 0101 always takes out; 0111 sends count
// - counted send uses count register bits 3..0
// - zero-length send carries no bytes
// - status check: zero length, toggle one
// - ignore means no handshake at all
// - accepted valid setup is answered with ack
// - 1001 acks out unless stalled, then 1000
// - 1000 naks out, ignores setup and in
// - 1011 acks out, then becomes 1010
// - 1010 accepts setup, zero in, naks out
// - 1101 sends count unless stalled, then 1100
// - 1100 naks in, ignores setup and out
// - 1111 sends count, checks out, then 1110
// - 1110 accepts setup, naks in, checks out
// - 1111 becomes 1110 after acked status out
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "usb_ep_consts.svh"
module usb_endpoint_mode_responder
#(
  parameter int COUNT_W = 4
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire usb_ep_pkg::apb_req_t apb_req,
  output usb_ep_pkg::apb_rsp_t apb_rsp,
  // decoded tokens from the serial engine
  input wire usb_ep_pkg::token_t token,
  input wire logic host_ack,
  // answer to the serial engine
  output usb_ep_pkg::resp_t resp
);
  ////////////////////////////////////////////////////////////////////////
  // register state

  logic [3:0] mode_ff;
  logic [3:0] nxt_mode;
  logic stall_ff;
  logic ctrl_ep_ff;
  logic [COUNT_W-1:0] count_ff;
  logic [3:0] status_ff;
  logic [3:0] nxt_status;
  usb_ep_pkg::resp_kind_t last_resp_ff;
  usb_ep_pkg::in_state_t in_state_ff;
  usb_ep_pkg::in_state_t nxt_in_state;
  usb_ep_pkg::resp_t resp_ff;
  usb_ep_pkg::resp_t nxt_resp;
  usb_ep_pkg::resp_kind_t dec_resp;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic hit;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == `UEP_MODE_ADDR) || (a == `UEP_COUNT_ADDR) ||
                  (a == `UEP_STATUS_ADDR);
  endfunction : addr_mapped

  assign addr = apb_req.paddr[7:0];
  assign hit = addr_mapped(addr) && (apb_req.paddr[31:8] == 24'h000000);
  // zero wait states: every access completes in its first access cycle
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && hit;
  assign rd_en = apb_req.psel && apb_req.penable && !apb_req.pwrite;

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = pslverr_ff;
  assign apb_rsp.prdata = prdata_ff;

  // error is presented combinationally in the access cycle
  always_comb
  begin
    pslverr_ff = apb_req.psel && apb_req.penable && !hit;
  end

  always_comb
  begin
    prdata_ff = 32'h00000000;
    if (rd_en && hit)
    begin
      case (addr)
        `UEP_MODE_ADDR:
        begin
          prdata_ff[`UEP_MODE_LSB +: 4] = mode_ff;
          prdata_ff[`UEP_CTRL_BIT] = ctrl_ep_ff;
          prdata_ff[`UEP_STALL_BIT] = stall_ff;
        end
        `UEP_COUNT_ADDR:
        begin
          prdata_ff[`UEP_COUNT_LSB +: COUNT_W] = count_ff;
        end
        `UEP_STATUS_ADDR:
        begin
          prdata_ff[3:0] = status_ff;
          prdata_ff[`UEP_ST_RESP_LSB +: 3] = last_resp_ff;
        end
        default:
        begin
          prdata_ff = 32'h00000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // packet checks and answer lookup

  logic setup_ok;
  logic status_ok;
  logic tok_setup;
  logic tok_in;
  logic tok_out;

  assign tok_setup = token.valid && (token.kind == usb_ep_pkg::TOK_SETUP);
  assign tok_in = token.valid && (token.kind == usb_ep_pkg::TOK_IN);
  assign tok_out = token.valid && (token.kind == usb_ep_pkg::TOK_OUT);
  assign setup_ok = token.crc_ok && (token.length <= `UEP_SETUP_MAX_LEN);
  assign status_ok = token.crc_ok && (token.length == 5'h00) &&
                     token.data_toggle_flag;

  ep_mode_decoder u_decoder
  (
    .mode(usb_ep_pkg::ep_mode_t'(mode_ff)),
    .stall(stall_ff),
    .kind(token.kind),
    .setup_ok(setup_ok),
    .status_ok(status_ok),
    .resp(dec_resp)
  );

  ////////////////////////////////////////////////////////////////////////
  // automatic mode changes

  logic out_acked;
  logic in_acked;

  assign out_acked = tok_out && (dec_resp == usb_ep_pkg::RESP_ACK);
  assign in_acked = host_ack && (in_state_ff == usb_ep_pkg::ST_WAIT_HOST_ACK) &&
                    !token.valid;

  // hardware changes win over a firmware write in the same cycle, so
  // a transaction already answered is never lost to a late re-arm
  always_comb
  begin
    nxt_mode = mode_ff;
    if (wr_en && addr == `UEP_MODE_ADDR)
    begin
      nxt_mode = apb_req.pwdata[`UEP_MODE_LSB +: 4];
    end
    if (tok_setup && ctrl_ep_ff && mode_ff != usb_ep_pkg::MODE_DISABLE)
    begin
      nxt_mode = usb_ep_pkg::MODE_NAK_INOUT;
    end
    else if (out_acked)
    begin
      case (mode_ff)
        usb_ep_pkg::MODE_ACK_OUT: nxt_mode = usb_ep_pkg::MODE_NAK_OUT;
        usb_ep_pkg::MODE_ACK_OUT_STIN: nxt_mode = usb_ep_pkg::MODE_NAK_OUT_STIN;
        usb_ep_pkg::MODE_ACK_IN_STOUT: nxt_mode = usb_ep_pkg::MODE_NAK_IN_STOUT;
        default: nxt_mode = nxt_mode;
      endcase
    end
    else if (in_acked)
    begin
      case (mode_ff)
        usb_ep_pkg::MODE_ACK_IN: nxt_mode = usb_ep_pkg::MODE_NAK_IN;
        usb_ep_pkg::MODE_ACK_IN_STOUT: nxt_mode = usb_ep_pkg::MODE_NAK_IN_STOUT;
        default: nxt_mode = nxt_mode;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_ff <= `UEP_MODE_RST;
    end
    else
    begin
      mode_ff <= nxt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stall, control flag and byte count

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stall_ff <= 1'b0;
      ctrl_ep_ff <= 1'b0;
    end
    else if (wr_en && addr == `UEP_MODE_ADDR)
    begin
      stall_ff <= apb_req.pwdata[`UEP_STALL_BIT];
      ctrl_ep_ff <= apb_req.pwdata[`UEP_CTRL_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_ff <= COUNT_W'(`UEP_COUNT_RST);
    end
    else if (wr_en && addr == `UEP_COUNT_ADDR)
    begin
      count_ff <= apb_req.pwdata[`UEP_COUNT_LSB +: COUNT_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // waiting for the host handshake after counted data

  always_comb
  begin
    nxt_in_state = in_state_ff;
    case (in_state_ff)
      usb_ep_pkg::ST_IDLE:
      begin
        if (tok_in && dec_resp == usb_ep_pkg::RESP_TX_COUNT)
        begin
          nxt_in_state = usb_ep_pkg::ST_WAIT_HOST_ACK;
        end
      end
      usb_ep_pkg::ST_WAIT_HOST_ACK:
      begin
        // a new token means the host never acked; drop the wait
        if (host_ack || token.valid)
        begin
          nxt_in_state = (tok_in && dec_resp == usb_ep_pkg::RESP_TX_COUNT)
                         ? usb_ep_pkg::ST_WAIT_HOST_ACK : usb_ep_pkg::ST_IDLE;
        end
      end
      default:
      begin
        nxt_in_state = usb_ep_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      in_state_ff <= usb_ep_pkg::ST_IDLE;
    end
    else
    begin
      in_state_ff <= nxt_in_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer register

  always_comb
  begin
    nxt_resp.valid = token.valid && (dec_resp != usb_ep_pkg::RESP_NONE);
    nxt_resp.kind = token.valid ? dec_resp : usb_ep_pkg::RESP_NONE;
    nxt_resp.byte_count = (dec_resp == usb_ep_pkg::RESP_TX_COUNT)
                          ? 4'(count_ff) : 4'h0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      resp_ff <= '0;
    end
    else
    begin
      resp_ff <= nxt_resp;
    end
  end

  assign resp = resp_ff;

  ////////////////////////////////////////////////////////////////////////
  // sticky traffic status, write one to clear, set wins

  always_comb
  begin
    nxt_status = status_ff;
    if (wr_en && addr == `UEP_STATUS_ADDR)
    begin
      nxt_status = status_ff & ~apb_req.pwdata[3:0];
    end
    if (tok_setup && dec_resp != usb_ep_pkg::RESP_NONE)
    begin
      nxt_status[`UEP_ST_SETUP_BIT] = 1'b1;
    end
    if (tok_in && dec_resp != usb_ep_pkg::RESP_NONE)
    begin
      nxt_status[`UEP_ST_IN_BIT] = 1'b1;
    end
    if (tok_out && dec_resp != usb_ep_pkg::RESP_NONE)
    begin
      nxt_status[`UEP_ST_OUT_BIT] = 1'b1;
    end
    if ((token.valid && dec_resp == usb_ep_pkg::RESP_ACK) || in_acked)
    begin
      nxt_status[`UEP_ST_ACK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_ff <= 4'h0;
      last_resp_ff <= usb_ep_pkg::RESP_NONE;
    end
    else
    begin
      status_ff <= nxt_status;
      if (token.valid)
      begin
        last_resp_ff <= dec_resp;
      end
    end
  end
endmodule : usb_endpoint_mode_responder
`default_nettype wire

// ==== testbench/usb_endpoint_mode_responder_asserts.sv ====
// port checker for the endpoint token responder
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_mode_responder_asserts
#(
  parameter int COUNT_W = 4
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire usb_ep_pkg::apb_req_t apb_req,
  input wire usb_ep_pkg::apb_rsp_t apb_rsp,
  // tokens and answer
  input wire usb_ep_pkg::token_t token,
  input wire logic host_ack,
  input wire usb_ep_pkg::resp_t resp
);
  logic [3:0] count_ff;
  logic acc;
  assign acc = apb_req.psel && apb_req.penable;
  // shadow of the count register; tokens never share a cycle with writes
  always_ff @(posedge clk)
  begin
    if (rst)
      count_ff <= 4'h0;
    else if (acc && apb_req.pwrite && apb_req.paddr == 32'h4)
      count_ff <= apb_req.pwdata[3:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_resp_cause: assert property (resp.valid |-> $past(token.valid))
    else $error("answer without token");
  a_setup_ack: assert property (resp.valid && $past(token.kind) == usb_ep_pkg::TOK_SETUP |->
    resp.kind == usb_ep_pkg::RESP_ACK) else $error("setup answered other than ack");
  a_bad_setup: assert property (token.valid && token.kind == usb_ep_pkg::TOK_SETUP &&
    (!token.crc_ok || token.length > 5'h0A) |=> !resp.valid) else $error("bad setup answered");
  a_in_kinds: assert property (resp.valid && $past(token.kind) == usb_ep_pkg::TOK_IN |->
    resp.kind inside {usb_ep_pkg::RESP_NAK, usb_ep_pkg::RESP_STALL, usb_ep_pkg::RESP_TX_ZERO,
    usb_ep_pkg::RESP_TX_COUNT}) else $error("bad in answer");
  a_out_kinds: assert property (resp.valid && $past(token.kind) == usb_ep_pkg::TOK_OUT |->
    resp.kind inside {usb_ep_pkg::RESP_ACK, usb_ep_pkg::RESP_NAK, usb_ep_pkg::RESP_STALL,
    usb_ep_pkg::RESP_TAKE}) else $error("bad out answer");
  a_zero_empty: assert property (resp.valid && resp.kind != usb_ep_pkg::RESP_TX_COUNT |->
    resp.byte_count == 4'h0) else $error("bytes on uncounted answer");
  a_count_sent: assert property (resp.valid && resp.kind == usb_ep_pkg::RESP_TX_COUNT |->
    resp.byte_count == count_ff) else $error("counted send length wrong");
  a_unmapped_err: assert property (acc && !(apb_req.paddr inside {32'h0, 32'h4, 32'h8}) |->
    apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped access not refused");
endmodule : usb_endpoint_mode_responder_asserts
`default_nettype wire

// ==== testbench/usb_host_model.sv ====
// host side: issues tokens and acks counted data
`timescale 1ns/100ps
`default_nettype none
module usb_host_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requests from the bench
  input wire usb_ep_pkg::token_t req,
  input wire logic ack_en,
  // device side
  input wire usb_ep_pkg::resp_t resp,
  output var usb_ep_pkg::token_t token,
  output var logic host_ack
);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      token <= '0;
      host_ack <= 1'b0;
    end
    else
    begin
      // idle fields toggle so stale values are never trusted
      token <= req.valid ? req : (~token & 10'h1FF);
      host_ack <= ack_en && resp.valid && resp.kind == usb_ep_pkg::RESP_TX_COUNT;
    end
  end
endmodule : usb_host_model
`default_nettype wire

// ==== testbench/usb_endpoint_mode_responder_tb_top.sv ====
// self-checking bench for the endpoint token responder
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_mode_responder_tb_top;
  logic clk;
  logic rst;
  usb_ep_pkg::apb_req_t apb_req;
  usb_ep_pkg::apb_rsp_t apb_rsp;
  usb_ep_pkg::token_t req;
  usb_ep_pkg::token_t token;
  usb_ep_pkg::resp_t resp;
  logic ack_en;
  logic host_ack;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 32'h23b99709;
  int mode = 0;
  int cnt = 0;
  int stl = 0;
  int ctl = 0;
  int st = 0;
  int last = 0;
  int clr = 0;
  usb_endpoint_mode_responder #(.COUNT_W(4)) dut (.clk(clk), .rst(rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .token(token), .host_ack(host_ack), .resp(resp));
  usb_host_model host (.clk(clk), .rst(rst), .req(req), .ack_en(ack_en), .resp(resp),
    .token(token), .host_ack(host_ack));
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic apb(logic wr, logic [31:0] a, logic [31:0] d, output logic [31:0] rd, output logic err);
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do
      @(posedge clk);
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clk);
  endtask : apb
  ////////////////////////////////////////
  // reference answer; acked auto changes step the mode down by one, a control setup forces mode 1
  function automatic int answer(int k, int ok, int tg, int ln);
    int r;
    r = 0;
    if (k == 0)
    begin
      if (mode inside {1, 2, 3, 4, 6, 10, 11, 14, 15} && ok != 0 && ln <= 10)
        r = 1;
      if (ctl != 0 && mode != 0)
        mode = 1;
    end
    else if (k == 1)
    begin
      if (mode inside {1, 12, 14})
        r = 2;
      if (mode inside {2, 3} || (mode == 13 && stl != 0))
        r = 3;
      if (mode inside {6, 10, 11})
        r = 4;
      if (mode inside {7, 15} || (mode == 13 && stl == 0))
        r = 5;
    end
    else
    begin
      if (mode inside {1, 8, 10})
        r = 2;
      if (mode inside {3, 6} || (mode == 9 && stl != 0))
        r = 3;
      if (mode == 5)
        r = 6;
      if (mode == 11 || (mode == 9 && stl == 0))
        r = 1;
      if (mode inside {2, 14, 15})
        r = (ln == 0 && tg != 0) ? 1 : 3;
      if (r == 1 && mode inside {9, 11, 15})
        mode = mode - 1;
    end
    return r;
  endfunction : answer
  task automatic tok(int k, int ok, int tg, int ln);
    int r;
    r = answer(k, ok, tg, ln);
    req <= '{valid:1'b1, kind:usb_ep_pkg::token_kind_t'(k[1:0]), crc_ok:ok[0], data_toggle_flag:tg[0],
      length:ln[4:0]};
    @(posedge clk);
    req.valid <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(resp.valid), 32'(r != 0));
    if (r != 0)
    begin
      chk(32'(resp.kind), r);
      chk(32'(resp.byte_count), r == 5 ? cnt : 0);
    end
    if (r == 5 && ack_en && mode inside {13, 15})
      mode = mode - 1;
    // sticky traffic status and last answer kind
    last = r;
    if (r != 0)
      st = st | (1 << k);
    if (r == 1 || (r == 5 && ack_en))
      st = st | 8;
    repeat (3) @(posedge clk);
  endtask : tok
  ////////////////////////////////////////
  initial
  begin
    logic [31:0] rd;
    logic err;
    int k;
    rst = 1'b1;
    apb_req = '0;
    req = '0;
    ack_en = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 32'h0, 32'h0, rd, err);
    chk(rd, 32'h0);
    apb(1'b0, 32'hC, 32'h0, rd, err);
    chk({rd[30:0], err}, 32'h1);
    // first pass walks every mode with every token kind
    for (int i = 0; i < 300; i++)
    begin
      mode = (i < 48) ? i / 3 : $unsigned($random(seed)) % 16;
      stl = $random(seed) & 1;
      ctl = $random(seed) & 1;
      cnt = $random(seed) & 15;
      ack_en <= 1'($random(seed) & 1);
      apb(1'b1, 32'h0, {24'h0, stl[0], 2'b00, ctl[0], mode[3:0]}, rd, err);
      apb(1'b1, 32'h4, {28'h0, cnt[3:0]}, rd, err);
      for (int j = 0; j < 2; j++)
      begin
        k = (i < 48 && j == 0) ? i % 3 : $unsigned($random(seed)) % 3;
        tok(k, (k != 0) || ($random(seed) & 1), $random(seed) & 1,
          k == 0 ? ($random(seed) & 15) : ($random(seed) & 1));
      end
      apb(1'b0, 32'h0, 32'h0, rd, err);
      chk(rd, {24'h0, stl[0], 2'b00, ctl[0], mode[3:0]});
      apb(1'b0, 32'h4, 32'h0, rd, err);
      chk(rd, cnt);
      apb(1'b0, 32'h8, 32'h0, rd, err);
      chk(rd, {25'h0, last[2:0], st[3:0]});
      clr = $random(seed) & 15;
      apb(1'b1, 32'h8, clr, rd, err);
      st = st & ~clr;
    end
    conclude();
  end
endmodule : usb_endpoint_mode_responder_tb_top
bind usb_endpoint_mode_responder usb_endpoint_mode_responder_asserts #(.COUNT_W(COUNT_W)) u_chk (
  .clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .token(token), .host_ack(host_ack),
  .resp(resp));
`default_nettype wire
